// [hdl/tcp_pkg.sv]
// Purpose: shared constants for the timer compare / pwm core
// Assumes: apb byte addresses, 32-bit data, narrow registers in low bits
// Notes:   all offsets, field positions and reset values live here
package tcp_pkg;
    // apb register byte offsets
    localparam logic [7:0] OFS_CTRL0  = 8'h00; // run + clock select
    localparam logic [7:0] OFS_CTRL1  = 8'h04; // mode and pin fields
    localparam logic [7:0] OFS_CNT_LO = 8'h08; // counter bits 7..0, ro
    localparam logic [7:0] OFS_CNT_HI = 8'h0C; // counter bits 15..8, ro
    localparam logic [7:0] OFS_CMPA_L = 8'h10; // compare_a_low_byte
    localparam logic [7:0] OFS_CMPA_H = 8'h14; // compare_a_high_byte
    localparam logic [7:0] OFS_CMPP   = 8'h18; // compare_p_value
    localparam logic [7:0] OFS_FLAGS  = 8'h1C; // match flags, w1c

    // control0 field positions
    localparam int CTRL0_ON      = 3; // counter_on
    localparam int CTRL0_CKS_LSB = 4; // clock select, 3 bits
    // control1 field positions
    localparam int CTRL1_CCLR    = 0; // clear_select
    localparam int CTRL1_SWAP    = 1; // period_duty_swap
    localparam int CTRL1_INV     = 2; // output_invert
    localparam int CTRL1_OC      = 3; // output_initial_level
    localparam int CTRL1_IO_LSB  = 4; // pin_action_lo / pin_action_hi
    localparam int CTRL1_M_LSB   = 6; // mode_select_lo / mode_select_hi
    // flags field positions
    localparam int FLAG_A        = 0; // match_a_flag
    localparam int FLAG_P        = 1; // match_p_flag

    // reset values
    localparam logic [7:0] RST_BYTE  = 8'h00;
    localparam logic [15:0] RST_CNT  = 16'h0000;

    // counter landmarks
    localparam logic [15:0] CNT_MAX  = 16'hFFFF;
    localparam logic [16:0] CNT_FULL = 17'h10000; // 65536 clocks

    // operating modes
    localparam logic [1:0] MODE_CMP  = 2'b00;
    localparam logic [1:0] MODE_PWM  = 2'b10;
    localparam logic [1:0] MODE_TMR  = 2'b11;

    // pin actions, compare mode
    localparam logic [1:0] IO_NONE   = 2'b00;
    localparam logic [1:0] IO_LOW    = 2'b01;
    localparam logic [1:0] IO_HIGH   = 2'b10;
    localparam logic [1:0] IO_TOGGLE = 2'b11;
    // pin actions, pwm mode
    localparam logic [1:0] IO_INACT  = 2'b00;
    localparam logic [1:0] IO_ACT    = 2'b01;
    localparam logic [1:0] IO_PWM    = 2'b10;

    // timer clock dividers, in system clocks
    localparam logic [7:0] DIV_SYS4  = 8'h03; // terminal count /4
    localparam logic [7:0] DIV_SYS1  = 8'h00;
    localparam logic [7:0] DIV_16    = 8'h0F;
    localparam logic [7:0] DIV_64    = 8'h3F;
    localparam logic [7:0] DIV_256   = 8'hFF;
endpackage

// [hdl/tcp_cmp_if.sv]
// Purpose: carries counter and compare values to the comparator unit
// Assumes: single clock domain, purely combinational answers
// Notes:   match lines are valid every cycle, qualified by the core
`timescale 1ns/1ps
interface tcp_cmp_if;
    logic [15:0] cnt;     // current counter value
    logic [15:0] cmp_a;   // comparator a value
    logic [7:0]  cmp_p;   // comparator p value
    logic        swap;    // period_duty_swap
    logic        hit_a;   // counter is about to reach a
    logic        hit_p;   // counter is about to reach p period end
    logic        duty_on; // pwm active part of the period
    modport core (output cnt, cmp_a, cmp_p, swap,
                  input hit_a, hit_p, duty_on);
    modport cmp  (input cnt, cmp_a, cmp_p, swap,
                  output hit_a, hit_p, duty_on);
endinterface

// [hdl/tcp_tick.sv]
// Purpose: timer clock enable divider
// Assumes: select value may change at any time; divider restarts cleanly
// Notes:   tick is high one cycle per divided period (every cycle at /1), straight from a flip-flop
`timescale 1ns/1ps
module tcp_tick (
    input  wire logic       clk_sys, // system clock
    input  wire logic       rst,     // sync reset, active high
    input  wire logic [2:0] sel,     // clock select
    output logic            tick     // one-cycle timer clock enable
);
    logic [7:0] div_r;
    logic [7:0] term;

    // terminal count for the selected rate
    always_comb begin
        case (sel)
            3'h0:    term = tcp_pkg::DIV_SYS4;
            3'h1:    term = tcp_pkg::DIV_SYS1;
            3'h2:    term = tcp_pkg::DIV_16;
            3'h3:    term = tcp_pkg::DIV_64;
            default: term = tcp_pkg::DIV_256;
        endcase
    end

    // free-running divider; >= guards a select change mid-count
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            div_r <= 8'h00;
            tick  <= 1'b0;
        end else if (div_r >= term) begin
            div_r <= 8'h00;
            tick  <= 1'b1;
        end else begin
            div_r <= div_r + 8'h01;
            tick  <= 1'b0;
        end
    end
endmodule

// [hdl/tcp_match.sv]
// Purpose: comparator a, comparator p and pwm duty decision
// Assumes: counter advances by one per tick
// Notes:   hits flag the last count before the period end
`timescale 1ns/1ps
module tcp_match (
    tcp_cmp_if.cmp bus // compare values in, matches out
);
    logic [16:0] nxt;
    logic [16:0] p_len;

    assign nxt = {1'b0, bus.cnt} + 17'h00001;
    // p span: 256 times value, zero means full 65536
    assign p_len = (bus.cmp_p == 8'h00) ? tcp_pkg::CNT_FULL :
                   {1'b0, bus.cmp_p, 8'h00};

    // p checks only the top byte, so hits land on 256 multiples
    assign bus.hit_p = (nxt == p_len);
    // a value zero never matches; counter then overflows at ffff
    assign bus.hit_a = (bus.cmp_a != 16'h0000) &&
                       (nxt == {1'b0, bus.cmp_a});
    // duty at or past the period reads as always active
    assign bus.duty_on = bus.swap ? ({1'b0, bus.cnt} < p_len)
                                  : (bus.cnt < bus.cmp_a);
endmodule

// [hdl/tcp_top.sv]
// Purpose: 16-bit timer with two comparators, compare output and pwm
// Assumes: apb master holds requests; pins synchronous to clk_sys
// Notes:   one access cycle per transfer; unmapped addresses flag pslverr
//
// Contract
// - compare a held in low and high byte registers, rw, reset zero
// - comparator p checks only counter bits fifteen to eight
// - p period is 256 times value; zero gives 65536 with overflow
// - mode 00 compare output, 11 timer, 10 pwm with pin action 10
// - compare mode, clear select low: p match clears; p zero overflows
// - clear select low sets a flag and p flag on own matches
// - clear select high: a match clears, only a flag is set
// - compare a zero: counter overflows at ffff, no a flag
// - compare mode pin changes only on a match, never on p match
// - a match drives pin low, high or toggles; zero action keeps pin
// - counter on rising edge sets pin to initial level
// - timer mode counts and flags like compare mode, pin not driven
// - pwm: one compare sets period by clearing, other sets duty
// - pwm ignores clear select for the period
// - pwm sets separate a and p flags on each match
// - pwm initial level picks polarity; action enables or forces pin
// - output invert inverts the pwm waveform on the pin
// - swap zero: period 256 times p or 65536, duty is a
// - swap zero: duty at or above period gives full duty
// - swap one: period is a, duty 256 times p or 65536
// - compare action 00 none, 01 low, 10 high, 11 toggle
// - on rising clears counter; on falling stops and keeps value
//
// The APB register port and the address map are this design's own decisions.
`timescale 1ns/1ps
module tcp_top (
    input  wire logic        clk_sys,  // system clock, 20 mhz
    input  wire logic        rst,      // sync reset, active high
    input  wire logic        psel,     // apb select
    input  wire logic        penable,  // apb access phase
    input  wire logic        pwrite,   // apb write
    input  wire logic [7:0]  paddr,    // apb byte address
    input  wire logic [31:0] pwdata,   // apb write data
    output logic [31:0]      prdata,   // apb read data
    output logic             pready,   // apb ready
    output logic             pslverr,  // apb error, unmapped address
    output logic             tm_out,   // timer output pin level
    output logic             tm_out_en // high while pin driven
);
    // software visible state
    logic [7:0]  ctrl0_r;
    logic [7:0]  ctrl1_r;
    logic [7:0]  cmpa_lo_r;
    logic [7:0]  cmpa_hi_r;
    logic [7:0]  cmpp_r;
    logic        flag_a_r;
    logic        flag_p_r;
    // timer state
    logic [15:0] cnt_r;
    logic        on_d_r;
    logic        pin_r;
    logic        pin_nxt;
    // decode helpers
    logic        setup;
    logic        wr_en;
    logic        mapped;
    logic [31:0] rd_nxt;
    logic        tick;
    logic        on_bit;
    logic        on_rise;
    logic        run;
    logic [1:0]  mode;
    logic [1:0]  pin_act;
    logic        clr_sel;
    logic        ev_a;
    logic        ev_p;
    logic        clr_cnt;
    logic        pwm_lvl;

    tcp_cmp_if cmpb ();

    // apb phase decode; a write lands only at the completing edge
    assign setup = psel && !penable;
    assign wr_en = psel && penable && pready && pwrite;

    assign on_bit  = ctrl0_r[tcp_pkg::CTRL0_ON];
    assign mode    = ctrl1_r[tcp_pkg::CTRL1_M_LSB +: 2];
    assign pin_act = ctrl1_r[tcp_pkg::CTRL1_IO_LSB +: 2];
    assign clr_sel = ctrl1_r[tcp_pkg::CTRL1_CCLR];
    assign on_rise = on_bit && !on_d_r;
    assign run     = on_bit && on_d_r && tick;

    // comparator unit inputs
    assign cmpb.cnt   = cnt_r;
    assign cmpb.cmp_a = {cmpa_hi_r, cmpa_lo_r};
    assign cmpb.cmp_p = cmpp_r;
    assign cmpb.swap  = ctrl1_r[tcp_pkg::CTRL1_SWAP];

    tcp_match u_match (
        .bus (cmpb.cmp)
    );

    tcp_tick u_tick (
        .clk_sys (clk_sys),
        .rst     (rst),
        .sel     (ctrl0_r[tcp_pkg::CTRL0_CKS_LSB +: 3]),
        .tick    (tick)
    );

    // read mux and address map
    always_comb begin
        mapped = 1'b1;
        rd_nxt = 32'h0000_0000;
        case (paddr)
            tcp_pkg::OFS_CTRL0:  rd_nxt[7:0] = ctrl0_r & 8'h78;
            tcp_pkg::OFS_CTRL1:  rd_nxt[7:0] = ctrl1_r;
            tcp_pkg::OFS_CNT_LO: rd_nxt[7:0] = cnt_r[7:0];
            tcp_pkg::OFS_CNT_HI: rd_nxt[7:0] = cnt_r[15:8];
            tcp_pkg::OFS_CMPA_L: rd_nxt[7:0] = cmpa_lo_r;
            tcp_pkg::OFS_CMPA_H: rd_nxt[7:0] = cmpa_hi_r;
            tcp_pkg::OFS_CMPP:   rd_nxt[7:0] = cmpp_r;
            tcp_pkg::OFS_FLAGS:  rd_nxt[1:0] = {flag_p_r, flag_a_r};
            default:             mapped = 1'b0;
        endcase
    end

    // registered answer: ready rises for exactly one access cycle
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else if (setup) begin
            pready  <= 1'b1;
            pslverr <= !mapped;
            prdata  <= pwrite ? 32'h0000_0000 : rd_nxt;
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // control and compare registers, all clear at reset
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ctrl0_r   <= tcp_pkg::RST_BYTE;
            ctrl1_r   <= tcp_pkg::RST_BYTE;
            cmpa_lo_r <= tcp_pkg::RST_BYTE;
            cmpa_hi_r <= tcp_pkg::RST_BYTE;
            cmpp_r    <= tcp_pkg::RST_BYTE;
        end else if (wr_en) begin
            case (paddr)
                tcp_pkg::OFS_CTRL0:  ctrl0_r   <= pwdata[7:0] & 8'h78;
                tcp_pkg::OFS_CTRL1:  ctrl1_r   <= pwdata[7:0];
                tcp_pkg::OFS_CMPA_L: cmpa_lo_r <= pwdata[7:0];
                tcp_pkg::OFS_CMPA_H: cmpa_hi_r <= pwdata[7:0];
                tcp_pkg::OFS_CMPP:   cmpp_r    <= pwdata[7:0];
                default: ;
            endcase
        end
    end

    // run bit delayed once, to see its edges
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            on_d_r <= 1'b0;
        end else begin
            on_d_r <= on_bit;
        end
    end

    // match events and clear choice
    always_comb begin
        ev_a    = 1'b0;
        ev_p    = 1'b0;
        clr_cnt = 1'b0;
        case (mode)
            tcp_pkg::MODE_PWM: begin
                // clear select plays no part here
                ev_a    = run && cmpb.hit_a;
                ev_p    = run && cmpb.hit_p;
                clr_cnt = cmpb.swap ? ev_a : ev_p;
            end
            default: begin
                // compare, timer and the unsupported capture setting
                if (clr_sel) begin
                    ev_a    = run && cmpb.hit_a;
                    clr_cnt = ev_a;
                end else begin
                    ev_a    = run && cmpb.hit_a;
                    ev_p    = run && cmpb.hit_p;
                    clr_cnt = ev_p;
                end
            end
        endcase
    end

    // counter: restart on rising run bit, hold when off, wrap at ffff
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cnt_r <= tcp_pkg::RST_CNT;
        end else if (on_rise) begin
            cnt_r <= tcp_pkg::RST_CNT;
        end else if (run) begin
            if (clr_cnt) begin
                cnt_r <= tcp_pkg::RST_CNT;
            end else begin
                cnt_r <= cnt_r + 16'h0001;
            end
        end
    end

    // sticky flags; a hit in the clearing cycle wins over the clear
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            flag_a_r <= 1'b0;
            flag_p_r <= 1'b0;
        end else begin
            if (ev_a) begin
                flag_a_r <= 1'b1;
            end else if (wr_en && paddr == tcp_pkg::OFS_FLAGS &&
                         pwdata[tcp_pkg::FLAG_A]) begin
                flag_a_r <= 1'b0;
            end
            if (ev_p) begin
                flag_p_r <= 1'b1;
            end else if (wr_en && paddr == tcp_pkg::OFS_FLAGS &&
                         pwdata[tcp_pkg::FLAG_P]) begin
                flag_p_r <= 1'b0;
            end
        end
    end

    // pwm level before invert: active level follows initial level bit
    always_comb begin
        case (pin_act)
            tcp_pkg::IO_PWM:  pwm_lvl = cmpb.duty_on;
            tcp_pkg::IO_ACT:  pwm_lvl = 1'b1;
            default:          pwm_lvl = 1'b0;
        endcase
    end

    // compare pin state; p hits never reach it
    always_comb begin
        pin_nxt = pin_r;
        if (on_rise) begin
            pin_nxt = ctrl1_r[tcp_pkg::CTRL1_OC];
        end else if (ev_a && mode == tcp_pkg::MODE_CMP) begin
            case (pin_act)
                tcp_pkg::IO_LOW:    pin_nxt = 1'b0;
                tcp_pkg::IO_HIGH:   pin_nxt = 1'b1;
                tcp_pkg::IO_TOGGLE: pin_nxt = !pin_r;
                default:            pin_nxt = pin_r;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pin_r <= 1'b0;
        end else begin
            pin_r <= pin_nxt;
        end
    end

    // pin driver; timer mode leaves the pin to other functions
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            tm_out    <= 1'b0;
            tm_out_en <= 1'b0;
        end else begin
            case (mode)
                tcp_pkg::MODE_CMP: begin
                    tm_out    <= pin_nxt ^ ctrl1_r[tcp_pkg::CTRL1_INV];
                    tm_out_en <= 1'b1;
                end
                tcp_pkg::MODE_PWM: begin
                    // polarity then invert; waveform is one cycle late
                    tm_out    <= (pwm_lvl ~^ ctrl1_r[tcp_pkg::CTRL1_OC]) ^
                                 ctrl1_r[tcp_pkg::CTRL1_INV];
                    tm_out_en <= 1'b1;
                end
                default: begin
                    tm_out    <= 1'b0;
                    tm_out_en <= 1'b0;
                end
            endcase
        end
    end
endmodule

// [test/tcp_checker.sv]
// Purpose: port-level assertions for the timer compare / pwm core
// Assumes: apb writes commit at the edge with psel, penable, pready high
// Notes:   control fields are shadowed from the observed apb writes
`timescale 1ns/1ps
module tcp_chk (
    input wire logic        clk_sys,  // system clock
    input wire logic        rst,      // sync reset
    input wire logic        psel,     // apb select
    input wire logic        penable,  // apb access phase
    input wire logic        pwrite,   // apb write
    input wire logic [7:0]  paddr,    // apb address
    input wire logic [31:0] pwdata,   // apb write data
    input wire logic [31:0] prdata,   // apb read data
    input wire logic        pready,   // apb ready
    input wire logic        pslverr,  // apb error
    input wire logic        tm_out,   // pin level
    input wire logic        tm_out_en // pin driven
);
    logic [7:0] c1_r;  // control1 shadow
    logic       on_r;  // counter_on shadow
    logic [2:0] gap_r; // cycles since a control write, saturating
    logic       wr;    // write committing this edge
    assign wr = psel && penable && pready && pwrite;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    // shadows: pin settles a few edges after a control change
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            c1_r <= 8'h00;
            on_r <= 1'b0;
            gap_r <= 3'h0;
        end else begin
            if (wr && paddr == tcp_pkg::OFS_CTRL1) c1_r <= pwdata[7:0];
            if (wr && paddr == tcp_pkg::OFS_CTRL0)
                on_r <= pwdata[tcp_pkg::CTRL0_ON];
            if (wr && paddr <= tcp_pkg::OFS_CTRL1) gap_r <= 3'h0;
            else if (gap_r != 3'h7) gap_r <= gap_r + 3'h1;
        end
    end
    a_ready_next: assert property (psel && !penable |=> pready)
        else $error("pready missing after setup");
    a_ready_access: assert property (pready |-> psel && penable)
        else $error("pready outside access");
    a_err_map: assert property (pready && paddr[1:0] == 2'h0 |->
        pslverr == (paddr > tcp_pkg::OFS_FLAGS))
        else $error("pslverr wrong for address");
    a_upper_zero: assert property (pready && !pwrite |->
        prdata[31:8] == 24'h000000 && !(pslverr && prdata != 32'h0))
        else $error("read data upper bits set");
    a_on_initial: assert property (wr && paddr == tcp_pkg::OFS_CTRL0
        && pwdata[tcp_pkg::CTRL0_ON] && !on_r
        && c1_r[7:6] == tcp_pkg::MODE_CMP
        |-> ##2 tm_out == (c1_r[3] ^ c1_r[2]))
        else $error("pin not at initial level");
    a_cmp_hold: assert property (c1_r[7:6] == tcp_pkg::MODE_CMP
        && c1_r[5:4] == tcp_pkg::IO_NONE && gap_r >= 3'h3
        |-> $stable(tm_out))
        else $error("pin moved with no action");
    a_tmr_free: assert property (c1_r[7:6] == tcp_pkg::MODE_TMR
        && gap_r >= 3'h2 |-> !tm_out_en)
        else $error("pin driven in timer mode");
    a_pwm_drive: assert property (c1_r[7:6] == tcp_pkg::MODE_PWM
        && gap_r >= 3'h2 |-> tm_out_en)
        else $error("pin not driven in pwm mode");
    a_inact_level: assert property (c1_r[7:6] == tcp_pkg::MODE_PWM
        && c1_r[5:4] == tcp_pkg::IO_INACT && on_r && gap_r >= 3'h3
        |-> tm_out == (!c1_r[3] ^ c1_r[2]))
        else $error("forced inactive level wrong");
endmodule
bind tcp_top tcp_chk tcp_chk_i (.clk_sys(clk_sys), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .tm_out(tm_out), .tm_out_en(tm_out_en));

// [test/tcp_pin_mon.sv]
// Purpose: external circuit on the timer pin, measures its waveform
// Assumes: pin only meaningful while driven
// Notes:   period and high time latched at each rising edge
`timescale 1ns/1ps
module tcp_pin_mon (
    input  wire logic clk_sys, // system clock
    input  wire logic rst,     // sync reset
    input  wire logic clr,     // restart low count
    input  wire logic pin,     // pin level
    input  wire logic pin_en,  // pin driven
    output int        period,  // cycles between rising edges
    output int        high,    // high cycles in last period
    output int        lows     // low cycles since clr
);
    int   run_c;
    int   hi_c;
    logic last;
    // undriven pin is ignored, it may float to anything
    always_ff @(posedge clk_sys) begin
        if (rst || clr) begin
            lows <= 0;
        end else if (pin_en && !pin) begin
            lows <= lows + 1;
        end
        if (rst) begin
            period <= 0;
            high <= 0;
            run_c <= 0;
            hi_c <= 0;
            last <= 1'b0;
        end else if (pin_en) begin
            last <= pin;
            if (pin && !last) begin
                period <= run_c;
                high <= hi_c;
                run_c <= 1;
                hi_c <= 1;
            end else begin
                run_c <= run_c + 1;
                hi_c <= hi_c + int'(pin);
            end
        end
    end
endmodule

// [test/tb_top.sv]
// Purpose: self-checking bench for the timer compare / pwm core
// Assumes: timer clock select /1, one tick per system clock
// Notes:   pin waveform judged through the pin monitor
`timescale 1ns/1ps
module tb_top;
    logic        clk_sys, rst, psel, penable, pwrite, er, mclr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        pready, pslverr, tm_out, tm_out_en;
    int          err_count, cmp_count, per, hi, lo, a, p, e_per, e_hi;
    tcp_top tcp_top_i (.clk_sys(clk_sys), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .tm_out(tm_out), .tm_out_en(tm_out_en));
    tcp_pin_mon tcp_pin_mon_i (.clk_sys(clk_sys), .rst(rst), .clr(mclr),
        .pin(tm_out), .pin_en(tm_out_en), .period(per), .high(hi),
        .lows(lo));
    // 50 ns system clock
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] ad,
                       input logic [31:0] d);
        int n;
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            err_count++;
            final_report();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    function automatic logic [7:0] c1f(input logic [1:0] m, io,
                                       input logic oc, iv, sw, cc);
        return {m, io, oc, iv, sw, cc};
    endfunction
    // stop, configure, clear flags, restart with /1 clock
    task automatic run(input logic [7:0] c1, input logic [15:0] ca,
                       input logic [7:0] cp);
        apb(1'b1, tcp_pkg::OFS_CTRL0, 32'h0000_0010);
        apb(1'b1, tcp_pkg::OFS_CTRL1, {24'h0, c1});
        apb(1'b1, tcp_pkg::OFS_CMPA_L, {24'h0, ca[7:0]});
        apb(1'b1, tcp_pkg::OFS_CMPA_H, {24'h0, ca[15:8]});
        apb(1'b1, tcp_pkg::OFS_CMPP, {24'h0, cp});
        apb(1'b1, tcp_pkg::OFS_FLAGS, 32'h0000_0003);
        apb(1'b1, tcp_pkg::OFS_CTRL0, 32'h0000_0018);
        mclr <= 1'b1;
        @(posedge clk_sys);
        mclr <= 1'b0;
    endtask
    task automatic flags(input logic [31:0] e, input string nm);
        apb(1'b0, tcp_pkg::OFS_FLAGS, 32'h0);
        chk(nm, rd, e);
    endtask
    // main sequence
    initial begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        mclr = 1'b0;
        err_count = 0;
        cmp_count = 0;
        void'($urandom(8828));
        repeat (5) @(posedge clk_sys);
        rst <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            apb(1'b0, 8'(i * 4), 32'h0);
            chk("reset value", rd, 32'h0);
        end
        apb(1'b0, 8'h20, 32'h0);
        chk("unmapped error", {31'h0, er}, 32'h1);
        for (int i = 4; i < 7; i++) begin
            a = $urandom % 256;
            apb(1'b1, 8'(i * 4), 32'(a));
            apb(1'b0, 8'(i * 4), 32'h0);
            chk("compare byte", rd, 32'(a));
        end
        $display("registers done");
        for (int k = 0; k < 4; k++) begin
            run(c1f(2'h0, 2'(k), k != 2, 1'b0, 1'b0, 1'b1), 16'h0028,
                8'h00);
            cyc(60);
            chk("pin action", {31'h0, tm_out}, 32'(k == 0 || k == 2));
        end
        cyc(200);
        chk("toggle period", per, 80);
        p = 1 + $urandom % 3;
        run(c1f(2'h0, 2'h3, 1'b0, 1'b0, 1'b0, 1'b0), 16'h0064, 8'(p));
        cyc(1600 * p);
        chk("p period", per, 512 * p);
        flags(32'h3, "flags both");
        apb(1'b1, tcp_pkg::OFS_FLAGS, 32'h3);
        flags(32'h0, "flags cleared");
        run(c1f(2'h0, 2'h3, 1'b0, 1'b0, 1'b0, 1'b1), 16'h012C, 8'h01);
        cyc(1500);
        chk("a clear period", per, 600);
        flags(32'h1, "a flag only");
        $display("compare mode done");
        run(c1f(2'h3, 2'h0, 1'b0, 1'b0, 1'b0, 1'b0), 16'h0000, 8'h00);
        cyc(65600);
        flags(32'h2, "overflow flags");
        chk("pin released", {31'h0, tm_out_en}, 32'h0);
        // stop keeps the count; restart begins again from zero
        apb(1'b1, tcp_pkg::OFS_CTRL0, 32'h0000_0010);
        apb(1'b0, tcp_pkg::OFS_CNT_LO, 32'h0);
        a = int'(rd);
        cyc(50);
        apb(1'b0, tcp_pkg::OFS_CNT_LO, 32'h0);
        chk("count held", rd, 32'(a));
        apb(1'b1, tcp_pkg::OFS_CTRL0, 32'h0000_0018);
        cyc(100);
        apb(1'b0, tcp_pkg::OFS_CNT_LO, 32'h0);
        chk("count restart", rd, 32'h0000_0064);
        $display("timer mode done");
        for (int k = 0; k < 4; k++) begin
            a = (k == 2) ? 300 : (k == 3) ? 512 : 1 + $urandom % 255;
            e_per = (k == 2) ? a : 256;
            e_hi = (k == 2 || a >= 256) ? 256 : a;
            if (k == 1) e_hi = e_per - e_hi;
            run(c1f(2'h2, 2'h2, 1'b1, k == 1, k == 2, k[0]), 16'(a),
                8'h01);
            cyc(1500);
            if (e_hi == e_per) begin
                chk("full duty lows", lo, 0);
            end else begin
                chk("pwm period", per, e_per);
                chk("pwm high", hi, e_hi);
            end
            flags((a <= e_per) ? 32'h3 : 32'h2, "pwm flags");
        end
        run(c1f(2'h2, 2'h0, 1'b1, 1'b0, 1'b0, 1'b0), 16'h0040, 8'h01);
        cyc(20);
        chk("forced level", {31'h0, tm_out}, 32'h0);
        $display("pwm mode done");
        final_report();
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
endmodule
